// file: core/sfp_pkg.sv
package sfp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths, depths and counts
  localparam int         BYTE_W     = 8;
  localparam int         FIFO_DEPTH = 32;
  localparam int         CNT_W      = 3;
  localparam logic [2:0] BIT_ZERO   = 3'h0;
  localparam logic [2:0] BIT_ONE    = 3'h1;
  localparam logic [2:0] SINGLE_END = 3'h7;  // Last bit index, one lane
  localparam logic [2:0] DUAL_END   = 3'h3;  // Last bit pair index, two lanes
  localparam logic [7:0] TX_FILL    = 8'hFF; // Sent when no read data is offered

  ////////////////////////////////////////////////////////////////////////////
  // Frame states and output modes
  typedef enum logic [3:0] {
    SFP_STANDBY = 4'h1,
    SFP_ACTIVE  = 4'h2,
    SFP_HOLD    = 4'h4,
    SFP_FINISH  = 4'h8
  } sfp_state_type;

  typedef enum logic [1:0] {
    SFP_OUT_NONE   = 2'h0,
    SFP_OUT_SINGLE = 2'h1,
    SFP_OUT_DUAL   = 2'h2
  } sfp_out_type;

  ////////////////////////////////////////////////////////////////////////////
  // Pin and stream carriers
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } sfp_pin_in_type;

  typedef struct packed {
    logic so;     // Lane one in dual mode
    logic so_oe;
    logic si_o;   // Lane zero in dual mode
    logic si_oe;
  } sfp_pin_out_type;

  typedef struct packed {
    logic       first;  // Opcode byte of the frame
    logic [7:0] data;
  } sfp_rx_type;

  localparam int RX_W = $bits(sfp_rx_type);

  // Pins as seen while idle: deselected, no hold, no write protect
  localparam sfp_pin_in_type PIN_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                                          hold_n: 1'b1, wp_n: 1'b1};

endpackage

// file: core/sfp_core.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Receive buffer between the serial side and the user
module sfp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W:0]   CNT_FULL = (PTR_W + 1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic             push;
  logic             pop;

  // Honest flags straight from the fill count
  assign in_ready  = (count != CNT_FULL);
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = store[rd_ptr];

  // Storage, no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // sfp_fifo

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Selected only while chip select is low
// - Deselect means tri-stated output, then standby once the engine is idle
// - Input ignored while chip select is high
// - Standby waits for program or erase end
// - Input bits sampled on clock rising edges
// - Output changes on clock falling edges
// - Dual read turns input pin into lane zero
// - Output pin drives lane one in dual
// - Write protect low enables hardware locking
// - Floating write protect reads as deasserted
// - Hold ignores clock, tri-states output
module sfp_core (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     reset_n,
  // Serial pins
  input  wire sfp_pkg::sfp_pin_in_type  pins_in,
  output sfp_pkg::sfp_pin_out_type      pins_out,
  // Received bytes
  output logic                          rx_valid,
  input  wire logic                     rx_ready,
  output sfp_pkg::sfp_rx_type           rx_word,
  output logic                          rx_overrun,
  // Read data to send
  input  wire sfp_pkg::sfp_out_type     tx_mode,
  input  wire logic                     tx_valid,
  input  wire logic [7:0]               tx_data,
  output logic                          tx_ready,
  // Frame and device status
  input  wire logic                     engine_busy,
  output logic                          frame_start,
  output logic                          frame_end,
  output logic                          selected,
  output logic                          standby,
  output logic                          lock_enable
);
  import sfp_pkg::*;

  sfp_pin_in_type pin_meta;
  sfp_pin_in_type pin_sync;
  logic           sck_prev;
  logic           cs_prev;
  logic           sck_rise;
  logic           sck_fall;
  logic           cs_fall;
  logic           cs_rise;
  sfp_state_type  state;
  sfp_state_type  next_state;
  logic           shifting;
  logic [7:0]     rx_shift;
  logic [2:0]     rx_count;
  logic           byte_first;
  logic           rx_done;
  sfp_rx_type     pend_word;
  logic           pend_valid;
  logic           pend_ready;
  logic [7:0]     tx_shift;
  logic [2:0]     tx_count;
  logic [7:0]     cur_byte;
  logic [1:0]     top_pair;
  logic           tx_step;
  logic           drive;
  logic           so_bit;
  logic           lane0_bit;
  logic           out_on;

  //////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers; the serial clock is only sampled, never used
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      sck_prev <= 1'b0;
      cs_prev  <= 1'b1;
    end else begin
      pin_meta <= pins_in;
      pin_sync <= pin_meta;
      sck_prev <= pin_sync.sck;
      cs_prev  <= pin_sync.cs_n;
    end
  end

  // Edges found on synchronised levels only
  assign sck_rise = pin_sync.sck && !sck_prev;
  assign sck_fall = !pin_sync.sck && sck_prev;
  assign cs_fall  = cs_prev && !pin_sync.cs_n;
  assign cs_rise  = !cs_prev && pin_sync.cs_n;

  //////////////////////////////////////////////////////////////////////////////
  // Frame state
  always_comb begin
    next_state = state;
    case (state)
      SFP_STANDBY: begin
        if (cs_fall) begin
          next_state = SFP_ACTIVE;
        end
      end
      SFP_ACTIVE, SFP_HOLD: begin
        if (pin_sync.cs_n) begin
          next_state = engine_busy ? SFP_FINISH : SFP_STANDBY;
        end else if (state == SFP_ACTIVE && !pin_sync.hold_n && !pin_sync.sck) begin
          next_state = SFP_HOLD;
        end else if (state == SFP_HOLD && pin_sync.hold_n) begin
          next_state = SFP_ACTIVE;
        end
      end
      SFP_FINISH: begin
        // Status polls may open a frame while the engine still runs
        if (cs_fall) begin
          next_state = SFP_ACTIVE;
        end else if (!engine_busy) begin
          next_state = SFP_STANDBY;
        end
      end
      default: next_state = SFP_STANDBY;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= SFP_STANDBY;
    end else begin
      state <= next_state;
    end
  end

  // Traffic counts only while selected and not held
  assign shifting = (state == SFP_ACTIVE) && !pin_sync.cs_n;

  //////////////////////////////////////////////////////////////////////////////
  // Receive shifter, MSB first, first byte flagged as opcode
  assign rx_done = shifting && sck_rise && (tx_mode != SFP_OUT_DUAL)
                   && (rx_count == SINGLE_END);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_shift   <= 8'h00;
      rx_count   <= BIT_ZERO;
      byte_first <= 1'b1;
    end else if (cs_fall) begin
      rx_count   <= BIT_ZERO;
      byte_first <= 1'b1;
    end else if (shifting && sck_rise && tx_mode != SFP_OUT_DUAL) begin
      rx_shift <= {rx_shift[6:0], pin_sync.si};
      rx_count <= rx_count + BIT_ONE;
      if (rx_done) begin
        byte_first <= 1'b0;
      end
    end
  end

  // One-byte holding slot; a full buffer stalls it, a second byte overruns
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pend_word  <= '0;
      pend_valid <= 1'b0;
      rx_overrun <= 1'b0;
    end else begin
      rx_overrun <= rx_done && pend_valid && !pend_ready;
      if (rx_done) begin
        pend_word  <= '{first: byte_first, data: {rx_shift[6:0], pin_sync.si}};
        pend_valid <= 1'b1;  // New byte wins over the drain
      end else if (pend_ready) begin
        pend_valid <= 1'b0;
      end
    end
  end

  sfp_fifo #(
    .WIDTH (RX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (pend_valid),
    .in_ready  (pend_ready),
    .in_data   (pend_word),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Transmit shifter, one or two bits per falling edge
  assign tx_step  = shifting && sck_fall && (tx_mode != SFP_OUT_NONE);
  assign tx_ready = tx_step && (tx_count == BIT_ZERO);
  assign cur_byte = (tx_count == BIT_ZERO) ? (tx_valid ? tx_data : TX_FILL) : tx_shift;
  assign top_pair = cur_byte[7:6];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_shift  <= 8'h00;
      tx_count  <= BIT_ZERO;
      drive     <= 1'b0;
      so_bit    <= 1'b0;
      lane0_bit <= 1'b0;
    end else if (cs_fall || pin_sync.cs_n) begin
      tx_count <= BIT_ZERO;
      drive    <= 1'b0;
    end else if (tx_step) begin
      drive <= 1'b1;
      if (tx_mode == SFP_OUT_DUAL) begin
        so_bit    <= cur_byte[7];
        lane0_bit <= cur_byte[6];
        tx_shift  <= {cur_byte[5:0], 2'b00};
        tx_count  <= (tx_count == DUAL_END) ? BIT_ZERO : tx_count + BIT_ONE;
      end else begin
        so_bit   <= cur_byte[7];
        tx_shift <= {cur_byte[6:0], 1'b0};
        tx_count <= (tx_count == SINGLE_END) ? BIT_ZERO : tx_count + BIT_ONE;
      end
    end
  end

  // Drivers off at once when deselected; hold only takes effect with the serial clock low
  assign out_on   = drive && shifting && (tx_mode != SFP_OUT_NONE);
  assign pins_out = '{so: so_bit, so_oe: out_on, si_o: lane0_bit,
                      si_oe: out_on && (tx_mode == SFP_OUT_DUAL)};

  //////////////////////////////////////////////////////////////////////////////
  // Status; the pad pull-up keeps a floating protect pin high
  assign frame_start = cs_fall;
  assign frame_end   = cs_rise && (state == SFP_ACTIVE || state == SFP_HOLD);
  assign selected    = !pin_sync.cs_n;
  assign standby     = (state == SFP_STANDBY);
  assign lock_enable = !pin_sync.wp_n;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  deselect_tristate_a: assert property (pin_sync.cs_n |-> !pins_out.so_oe && !pins_out.si_oe)
    else $error("output driven while deselected");
  deselect_nostore_a: assert property (pin_sync.cs_n |=> $stable(rx_count) && $stable(rx_shift))
    else $error("input stored while deselected");
  select_only_low_a: assert property (pin_sync.cs_n |=> state != SFP_ACTIVE && state != SFP_HOLD)
    else $error("frame state kept while deselected");
  busy_standby_a: assert property ((state == SFP_FINISH && engine_busy && !cs_fall)
                                   |=> state == SFP_FINISH)
    else $error("standby before engine done");
  rise_sample_a: assert property ((!sck_rise && !cs_fall) |=> $stable(rx_shift))
    else $error("input sampled off rising edge");
  fall_drive_a: assert property (!sck_fall |=> $stable(pins_out.so) && $stable(pins_out.si_o))
    else $error("output changed off falling edge");
  dual_pair_a: assert property ((tx_step && tx_mode == SFP_OUT_DUAL)
                                |=> {pins_out.so, pins_out.si_o} == $past(top_pair))
    else $error("dual lanes carry wrong bit pair");
  dual_lanes_a: assert property ((pins_out.so_oe && tx_mode == SFP_OUT_DUAL) |-> pins_out.si_oe)
    else $error("lane zero idle in dual read");
  hold_quiet_a: assert property (state == SFP_HOLD |-> !pins_out.so_oe ##1 $stable(rx_count))
    else $error("activity during hold");
  opcode_first_a: assert property (cs_fall |=> rx_count == BIT_ZERO && byte_first)
    else $error("frame start does not reset opcode");
  // Judged against the raw pin two samples back, so the synchroniser is covered too
  lock_wp_a: assert property (lock_enable == !$past(pins_in.wp_n, 2))
    else $error("lock does not follow protect pin");

  dual_read_c: cover property (tx_step && tx_mode == SFP_OUT_DUAL ##1 pins_out.si_oe);
  hold_seen_c: cover property (state == SFP_ACTIVE ##1 state == SFP_HOLD);
  finish_wait_c: cover property (state == SFP_FINISH ##1 state == SFP_STANDBY);
  overrun_c: cover property (rx_overrun);
endmodule // sfp_core

// file: bench/sfp_host_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Host controller on the far side of the pins, clock idles low
module sfp_host_model (
  // Alignment clock
  input  wire logic                     clock,
  // Pins
  input  wire sfp_pkg::sfp_pin_out_type pins_out,
  output sfp_pkg::sfp_pin_in_type       pins_in
);
  import sfp_pkg::*;

  logic cs_n     = 1'b1;
  logic sck      = 1'b0;
  logic si_host  = 1'b0;
  logic si_drive = 1'b1;
  logic hold_n   = 1'b1;
  logic wp_val   = 1'b0;
  logic wp_float = 1'b1;
  logic si_idle  = 1'b0;

  // Released lane toggles, so a stale bit never passes for data
  always @(negedge clock) begin
    if (!si_drive) begin
      si_idle <= ~si_idle;
    end
  end
  // Device lane wins while enabled; floating protect pin pulled high
  assign pins_in = {cs_n, sck,
                    pins_out.si_oe ? pins_out.si_o : (si_drive ? si_host : si_idle),
                    hold_n, wp_float | wp_val};

  ////////////////////////////////////////////////////////////////////////////
  // One bit: launched while low, both lanes sampled on the rise
  task automatic bit_cycle(input logic din, output logic [1:0] dout);
    si_host = din;
    #32 sck = 1'b1;
    dout = {pins_out.so_oe ? pins_out.so : 1'bz, pins_in.si};
    #32 sck = 1'b0;
  endtask

  // Frame edge, then a quiet gap of eight system clocks
  task automatic select(input logic on);
    cs_n     = !on;
    si_drive = 1'b1;
    #32;
  endtask

  // One byte out and one back, single lane or both lanes
  task automatic xfer(input logic [7:0] tx, input logic dual, output logic [7:0] rx);
    logic [1:0] d;
    rx       = 8'h00;
    si_drive = !dual;
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      bit_cycle(tx[7-i], d);
      rx = dual ? {rx[5:0], d} : {rx[6:0], d[1]};
    end
  endtask

  // Loose clocks with no byte framing
  task automatic stub(input int n);
    logic [1:0] d;
    repeat (n) bit_cycle(1'b1, d);
  endtask

  // Pause taken with clock low; the clocks inside must be ignored
  task automatic pause;
    hold_n = 1'b0;
    #32;
    stub(2);
    hold_n = 1'b1;
    #32;
  endtask
endmodule // sfp_host_model

// file: bench/testbench.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the serial pin interface
module testbench;
  import sfp_pkg::*;

  logic            clock = 1'b0, reset_n = 1'b0, rx_ready = 1'b0, stall = 1'b0;
  logic            tx_valid = 1'b0, engine_busy = 1'b0;
  logic            rx_valid, rx_overrun, tx_ready, frame_start, frame_end;
  logic            selected, standby, lock_enable;
  logic [7:0]      tx_data = 8'h00;
  sfp_pin_in_type  pins_in;
  sfp_pin_out_type pins_out;
  sfp_rx_type      rx_word;
  sfp_out_type     tx_mode = SFP_OUT_NONE, mode_plan = SFP_OUT_NONE;
  integer          seed = 53;
  int              err_total = 0, n_compared = 0, cycles = 0, frames = 0, overruns = 0;
  sfp_rx_type      exp_rx[$];
  logic [7:0]      tx_q[$], exp_rd[$];

  sfp_core sfp_core_i (.clock(clock), .reset_n(reset_n), .pins_in(pins_in),
    .pins_out(pins_out), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
    .rx_overrun(rx_overrun), .tx_mode(tx_mode), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .engine_busy(engine_busy), .frame_start(frame_start),
    .frame_end(frame_end), .selected(selected), .standby(standby),
    .lock_enable(lock_enable));
  sfp_host_model host_i (.clock(clock), .pins_out(pins_out), .pins_in(pins_in));

  initial forever #2 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  // Compare, count, report
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("Compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bounded wait until every noted word has come out
  task automatic drain;
    for (int k = 0; k < 3000 && exp_rx.size() > 0; k++) @(negedge clock);
  endtask

  // Opcode and payload written, then reads; outcomes noted before sending
  task automatic frame(input int n_wr, input int n_rd, input sfp_out_type mode,
                       input logic hold);
    logic [7:0] b, r;
    drain();
    mode_plan = mode;
    for (int i = 1; i < n_rd; i++) begin
      b = 8'($random(seed));
      tx_q.push_back(b);
      exp_rd.push_back(b);
    end
    if (n_rd > 0) exp_rd.push_back(TX_FILL);
    host_i.select(1'b1);
    check("sel_stby", 9'({selected, standby}), 9'h002);
    for (int i = 0; i < n_wr + n_rd; i++) begin
      b = (i < n_wr) ? 8'($random(seed)) : 8'h00;
      // Dual reads shift nothing in; the word overwritten on overrun is lost
      if ((i < n_wr || mode != SFP_OUT_DUAL) && !(stall && i == 32))
        exp_rx.push_back({i == 0, b});
      host_i.xfer(b, i >= n_wr && mode == SFP_OUT_DUAL, r);
      if (i >= n_wr) check("read", 9'(r), 9'(exp_rd.pop_front()));
      if (hold && i == 1) host_i.pause();
    end
    if (hold) host_i.stub(3);
    host_i.select(1'b0);
    check("oe", 9'({pins_out.so_oe, pins_out.si_oe}), 9'h000);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // User inputs: random drain, mode decode on the opcode, read bytes offered
  always @(negedge clock) begin
    rx_ready <= !stall && (($random(seed) & 1) != 0);
    if (frame_start === 1'b1) tx_mode <= SFP_OUT_NONE;
    else if (rx_valid === 1'b1 && rx_word.first === 1'b1) tx_mode <= mode_plan;
    tx_valid <= (tx_q.size() > 0);
    tx_data  <= (tx_q.size() > 0) ? tx_q[0] : 8'h00;
  end

  // Output watcher: oldest note against each word taken
  always @(posedge clock) begin
    cycles++;
    if (tx_ready === 1'b1 && tx_q.size() > 0) void'(tx_q.pop_front());
    if (rx_overrun === 1'b1) overruns++;
    if (frame_end === 1'b1) frames++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_rx.size() == 0) check("rx_extra", 9'h001, 9'h000);
      else check("rx_word", rx_word, exp_rx.pop_front());
    end
    // Hang guard, far above the few thousand cycles needed
    if (cycles == 40000) begin
      err_total++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    repeat (8) @(negedge clock);
    check("standby", 9'(standby), 9'h001);
    check("lock", 9'(lock_enable), 9'h000);
    host_i.wp_float = 1'b0;
    host_i.wp_val   = 1'b0;
    repeat (8) @(negedge clock);
    check("lock", 9'(lock_enable), 9'h001);
    host_i.stub(8);
    frame(4, 0, SFP_OUT_NONE, 1'b1);
    frame(1, 3, SFP_OUT_SINGLE, 1'b0);
    frame(1, 3, SFP_OUT_DUAL, 1'b0);
    engine_busy = 1'b1;
    frame(2, 0, SFP_OUT_NONE, 1'b0);
    check("standby", 9'(standby), 9'h000);
    engine_busy = 1'b0;
    repeat (4) @(negedge clock);
    check("standby", 9'(standby), 9'h001);
    // Empty the buffer before the drain stops, or the overrun count shifts
    drain();
    stall = 1'b1;
    frame(34, 0, SFP_OUT_NONE, 1'b0);
    check("overrun", 9'(overruns), 9'h001);
    stall = 1'b0;
    drain();
    check("frames", 9'(frames), 9'h005);
    check("left", 9'(exp_rx.size()), 9'h000);
    test_done();
  end
endmodule // testbench
